// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import bmx_pkg::*;
;
	logic core_clk, rst_b, instr_valid, ext_set_en, mem_we, flags_we;
	logic [15:0] instr_word;
	logic [11:0] index_base, mem_addr;
	logic [7:0] mem_wdata, accum, bank_select_reg, exp_acc;
	logic [1:0] q_phase;
	int bad_count = 0;
	int n_checks = 0;
	bmx_exec i_dut (.core_clk(core_clk), .rst_b(rst_b),
		.instr_word(instr_word), .instr_valid(instr_valid),
		.ext_set_en(ext_set_en), .index_base(index_base),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.accum(accum), .bank_select_reg(bank_select_reg),
		.q_phase(q_phase), .flags_we(flags_we));
	// ==========================================
	// Clock and helpers
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task results;
		if (bad_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Waits for the Q4 edge, then lets its updates land
	task run(input logic [15:0] w, input logic v);
		@(posedge core_clk);
		instr_word <= w;
		instr_valid <= v;
		#1;
		while (q_phase !== 2'b11) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1;
	endtask
	task la(input logic [7:0] k);
		run({8'h0e, k}, 1'b1);
		exp_acc = k;
		chk({4'h0, accum}, {4'h0, k});
		chk({11'h000, flags_we}, 12'h000);
	endtask
	task st(input logic [8:0] af, input logic [11:0] ea);
		run({OPC_STORE_ACCUM, af}, 1'b1);
		chk({11'h000, mem_we}, 12'h001);
		chk(mem_addr, ea);
		chk({4'h0, mem_wdata}, {4'h0, exp_acc});
		chk({3'h0, accum, flags_we}, {3'h0, exp_acc, 1'b0});
		@(posedge core_clk);
		#1;
		chk({11'h000, mem_we}, 12'h000);
	endtask
	// ==========================================
	// Scenarios
	task t_accum;
		la(8'h00);
		la(8'hff);
		la(8'h4f);
	endtask
	task t_bank;
		run(16'h01a3, 1'b1);
		chk({4'h0, bank_select_reg}, 12'h0a3);
		run(16'h0103, 1'b1);
		chk({4'h0, bank_select_reg}, 12'h003);
		chk({3'h0, accum, flags_we}, {3'h0, exp_acc, 1'b0});
	endtask
	task t_store;
		st(9'h120, 12'h320);
		st(9'h1ff, 12'h3ff);
		st(9'h010, 12'h010);
		st(9'h05f, 12'h05f);
		st(9'h060, 12'hf60);
	endtask
	task t_index;
		@(posedge core_clk);
		ext_set_en <= 1'b1;
		index_base <= 12'hfd0;
		st(9'h05f, 12'h02f);
		st(9'h000, 12'hfd0);
		st(9'h060, 12'hf60);
		st(9'h120, 12'h320);
		@(posedge core_clk);
		ext_set_en <= 1'b0;
	endtask
	// Dropped or foreign words must leave no trace
	task t_refuse;
		run({OPC_STORE_ACCUM, 9'h120}, 1'b0);
		chk({11'h000, mem_we}, 12'h000);
		run(16'h6d20, 1'b1);
		chk({11'h000, mem_we}, 12'h000);
		run(16'h0e11, 1'b0);
		chk({4'h0, accum}, {4'h0, exp_acc});
	endtask
	// Reset in mid-run clears state, then work resumes
	task t_reset;
		@(posedge core_clk);
		rst_b <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({4'h0, accum}, {4'h0, ACCUM_RESET});
		chk({4'h0, bank_select_reg}, {4'h0, BANK_RESET});
		chk(mem_addr, 12'h000);
		chk({1'b0, mem_we, q_phase, mem_wdata}, 12'h000);
		@(posedge core_clk);
		rst_b <= 1'b1;
		exp_acc = ACCUM_RESET;
		@(posedge core_clk);
		#1;
		chk({10'h000, q_phase}, 12'h001);
		la(8'h5a);
		st(9'h05a, 12'h05a);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		rst_b = 1'b0;
		instr_word = 16'h0000;
		instr_valid = 1'b0;
		ext_set_en = 1'b0;
		index_base = 12'h000;
		exp_acc = 8'h00;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		t_accum;
		t_bank;
		t_store;
		t_index;
		t_refuse;
		t_reset;
		results;
	end
	initial begin
		#20000;
		bad_count++;
		results;
	end
endmodule
`default_nettype wire

// ### verilog/bmx_exec.sv
// Behaviour
// - Literal load puts 8-bit immediate in accumulator
// - Store copies accumulator to file, flags untouched
// - Store opcode 0110111, bit8 access, low byte
// - File field addresses one 256-byte bank
// - Access bit 0 selects fixed access bank
// - Access bit 1 uses bank select register
// - Extended set, a=0, f<=5Fh: indexed offset
`timescale 1ns/1ps
`default_nettype none
module bmx_exec
	import bmx_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Instruction from decode stage, held for a whole cycle
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	// Data memory write port
	output logic mem_we,
	output logic [11:0] mem_addr,
	output logic [7:0] mem_wdata,
	// Architectural state
	output logic [7:0] accum,
	output logic [7:0] bank_select_reg,
	output logic [1:0] q_phase,
	output logic flags_we
);
	bmx_phase_type phase;
	logic [7:0] next_accum;
	logic [7:0] next_bank;
	logic next_we;
	logic [11:0] next_addr;
	logic [7:0] next_wdata;
	logic is_load_accum;
	logic is_load_bank;
	logic is_store;
	logic [7:0] fld;
	logic [11:0] eff_addr;

	// Phase sequencer, Q4 is the write phase
	bmx_phase_gen u_phase (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.phase(phase)
	);

	// ==========================================
	// Decode
	always_comb begin
		fld = instr_word[7:0];
		is_load_accum = instr_valid && instr_word[15:8] == OPC_LOAD_ACCUM;
		is_load_bank = instr_valid && instr_word[15:8] == OPC_LOAD_BANK;
		is_store = instr_valid && instr_word[15:9] == OPC_STORE_ACCUM;
	end

	// ==========================================
	// Effective address
	always_comb begin
		if (instr_word[ACCESS_BIT]) begin
			eff_addr = {bank_select_reg[3:0] & BANK_MASK, fld};
		end else if (ext_set_en && fld <= IDX_LIMIT) begin
			// Sum wraps at 12 bits like the data space
			// Indexed literal offset
			eff_addr = index_base + {4'h0, fld};
		end else if (fld < ACCESS_SPLIT) begin
			eff_addr = {ACCESS_LO_BANK, fld};
		end else begin
			// Fields from 60h up map to top bank
			eff_addr = {ACCESS_HI_BANK, fld};
		end
	end

	// ==========================================
	// Execute, all writes land in Q4
	always_comb begin
		next_accum = accum;
		next_bank = bank_select_reg;
		next_we = 1'b0;
		// Address and data hold, so memory sees no glitch
		next_addr = mem_addr;
		next_wdata = mem_wdata;
		if (phase == PH_Q4) begin
			if (is_load_accum) begin
				next_accum = fld;
			end
			if (is_load_bank) begin
				next_bank = fld;
			end
			// One of 256 locations per bank
			if (is_store) begin
				next_we = 1'b1;
				next_addr = eff_addr;
				next_wdata = accum;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			accum <= ACCUM_RESET;
			bank_select_reg <= BANK_RESET;
			mem_we <= 1'b0;
			mem_addr <= 12'h000;
			mem_wdata <= 8'h00;
		end else begin
			accum <= next_accum;
			bank_select_reg <= next_bank;
			mem_we <= next_we;
			mem_addr <= next_addr;
			mem_wdata <= next_wdata;
		end
	end

	// None of these instructions touches status
	assign flags_we = 1'b0;
	assign q_phase = phase;

	// ==========================================
	// Checks
	// Literal reaches accumulator
	AST_LOAD_ACCUM: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_load_accum |=> accum == $past(fld))
		else $error("accumulator not loaded");

	AST_ACCUM_HOLD: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		$changed(accum) |-> $past(phase) == PH_Q4
		&& $past(is_load_accum))
		else $error("accumulator changed without load");

	AST_STORE_DATA: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_store |=> mem_we && mem_wdata == $past(accum)
		&& $stable(accum))
		else $error("store data wrong");

	AST_WE_PULSE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		mem_we |=> !mem_we [*3])
		else $error("write strobe too long");

	AST_WE_AFTER_Q4: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		mem_we |-> $past(phase) == PH_Q4)
		else $error("write outside Q4");

	AST_ADDR_HOLD: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!mem_we |-> $stable(mem_addr) && $stable(mem_wdata))
		else $error("address or data moved without write");

	AST_STORE_DECODE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		mem_we |-> $past(instr_word[15:9]) == OPC_STORE_ACCUM)
		else $error("write without store opcode");

	AST_REFUSED: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && !instr_valid |=> !mem_we && $stable(accum)
		&& $stable(bank_select_reg))
		else $error("invalid word had an effect");

	AST_LOW_BYTE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		mem_we && !$past(ext_set_en) |-> mem_addr[7:0] == $past(fld))
		else $error("file field not used");

	AST_ACCESS_BANK: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_store && !instr_word[ACCESS_BIT] && !ext_set_en
		|=> mem_addr[11:8] == (mem_addr[7:0] < ACCESS_SPLIT ?
		ACCESS_LO_BANK : ACCESS_HI_BANK))
		else $error("access bank wrong");

	AST_BANKED: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_store && instr_word[ACCESS_BIT]
		|=> mem_addr[11:8] == $past(bank_select_reg[3:0]))
		else $error("bank select not used");

	AST_INDEXED: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_store && !instr_word[ACCESS_BIT] && ext_set_en
		&& fld <= IDX_LIMIT |=> mem_addr == $past(index_base)
		+ {4'h0, $past(fld)})
		else $error("indexed address wrong");

	AST_BANK_VALUE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 && is_load_bank
		|=> bank_select_reg == $past(fld))
		else $error("bank select not loaded");

	AST_BANK_Q4: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		$changed(bank_select_reg) |-> $past(phase) == PH_Q4
		&& $past(is_load_bank))
		else $error("bank select changed outside Q4");

	AST_ONE_CYCLE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		phase == PH_Q4 |=> phase == PH_Q1 ##1 phase == PH_Q2
		##1 phase == PH_Q3 ##1 phase == PH_Q4)
		else $error("phase sequence broken");
endmodule
`default_nettype wire

// ### verilog/bmx_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module bmx_phase_gen
	import bmx_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Phase
	output bmx_phase_type phase
);
	bmx_phase_type next_phase;

	// ==========================================
	// Four-phase sequencer
	always_comb begin
		case (phase)
			PH_Q1: next_phase = PH_Q2;
			PH_Q2: next_phase = PH_Q3;
			PH_Q3: next_phase = PH_Q4;
			PH_Q4: next_phase = PH_Q1;
			default: next_phase = PH_Q1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= PH_Q1;
		end else begin
			phase <= next_phase;
		end
	end
endmodule
`default_nettype wire

// ### verilog/bmx_pkg.sv
package bmx_pkg;
	// ==========================================
	// Instruction encoding
	localparam logic [7:0] OPC_LOAD_ACCUM = 8'h0e;
	localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
	localparam logic [6:0] OPC_STORE_ACCUM = 7'h37;
	localparam int ACCESS_BIT = 8;
	// ==========================================
	// Addressing
	localparam logic [7:0] IDX_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [7:0] ACCUM_RESET = 8'h00;
	localparam logic [3:0] BANK_MASK = 4'hf;
	// ==========================================
	// Phases
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} bmx_phase_type;
endpackage
